// File: logic/rcsc_pkg.sv
// constants and types of the remote common and status command interpreter
package rcsc_pkg;
  // commands delivered by the command parser
  typedef enum logic [4:0] {
    OP_IDNQ, OP_RST, OP_SAV, OP_RCL, OP_OPC, OP_OPCQ, OP_WAI, OP_TSTQ, OP_TRG,
    OP_CLS, OP_LSRQ, OP_LSE, OP_LSEQ, OP_EERQ, OP_QERQ, OP_STBQ, OP_SRE, OP_SREQ,
    OP_PRE, OP_PREQ, OP_ISTQ, OP_LOCAL, OP_LOCK, OP_LOCKQ, OP_NETCFG, OP_IP,
    OP_MASK, OP_NETCFGQ, OP_IPQ, OP_MASKQ
  } rcsc_op_type;
  typedef enum {ST_IDLE, ST_IDN} rcsc_state_type;
  localparam int          NUM_OUT      = 3;
  localparam int          SET_W        = 8;
  localparam int          STORE_DEPTH  = 50;
  localparam logic [5:0]  STORE_MAX    = 6'h31;
  localparam logic [1:0]  IDN_LAST     = 2'h3;
  // esr bits
  localparam int          ESR_OPC      = 0;
  localparam int          ESR_QYE      = 2;
  localparam int          ESR_EXE      = 4;
  // status byte bits
  localparam int          STB_MAV      = 4;
  localparam int          STB_ESB      = 5;
  localparam int          STB_RQS      = 6;
  // execution error codes
  localparam logic [7:0]  EER_RANGE    = 8'h68;
  localparam logic [7:0]  EER_LOCK     = 8'hc8;
  localparam logic [7:0]  EER_PARAM    = 8'h78;
  // register offsets
  localparam logic [7:0]  REG_STATUS   = 8'h00;
  localparam logic [7:0]  REG_SETTINGS = 8'h04;
  localparam logic [7:0]  REG_DEFAULT  = 8'h08;
  localparam logic [7:0]  REG_NET_IP   = 8'h0c;
  localparam logic [7:0]  REG_NET_MASK = 8'h10;
  // values after reset
  localparam logic [7:0]  DEFAULT_RST  = 8'h00;
  localparam logic [1:0]  METHOD_RST   = 2'h0;
  localparam logic [31:0] IP_RST       = 32'h00000000;
  localparam logic [31:0] MASK_RST     = 32'hffffff00;
endpackage

// File: logic/rcsc_top.sv
// remote common and status command interpreter of a triple-output supply
`timescale 1ns/1ps
module rcsc_top #(
  parameter logic [31:0] MAKER_CODE = 32'h00000001, // arbitrary value
  parameter logic [31:0] MODEL_CODE = 32'h00000002, // arbitrary value
  parameter logic [31:0] SERIAL_NUM = 32'h00000003, // arbitrary value
  parameter logic [31:0] FW_REV     = 32'h00000004  // arbitrary value
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // decoded commands
  input  wire logic                  cmd_valid,
  input  wire rcsc_pkg::rcsc_op_type cmd_op,
  input  wire logic [1:0]            cmd_chan,
  input  wire logic [1:0]            cmd_iface,
  input  wire logic [39:0]           cmd_arg,
  output logic                       cmd_ready,
  // responses
  output logic                       rsp_valid,
  output logic [31:0]                rsp_data,
  output logic                       rsp_last,
  // device events
  input  wire logic [2:0]            lim_evt,
  input  wire logic [7:0]            lim_bits,
  input  wire logic                  qry_err_set,
  input  wire logic [7:0]            qry_err_code,
  input  wire logic                  mav,
  input  wire logic                  range_blocked,
  input  wire logic [3:0]            iface_disabled,
  // network values stored in non-volatile memory
  input  wire logic [1:0]            boot_method,
  input  wire logic [31:0]           boot_ip,
  input  wire logic [31:0]           boot_mask,
  output logic [1:0]                 address_method_cmd,
  output logic [31:0]                static_ip_cmd,
  output logic [31:0]                net_mask_cmd,
  // device state
  output logic [23:0]                out_settings,
  output logic                       remote,
  output logic                       srq,
  output logic                       ist,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata
);
  logic [23:0]                 store_mem [rcsc_pkg::STORE_DEPTH];
  rcsc_pkg::rcsc_state_type    state_r, state_nxt;
  logic [1:0]                  idn_cnt_r, idn_cnt_nxt;
  logic                        rdy_r, rdy_nxt;
  logic                        rv_r, rv_nxt;
  logic [31:0]                 rd_r, rd_nxt;
  logic                        rl_r, rl_nxt;
  logic [7:0]                  esr_r, esr_nxt;
  logic [7:0]                  eer_r, eer_nxt;
  logic [7:0]                  qer_r, qer_nxt;
  logic [7:0]                  sre_r, sre_nxt;
  logic [7:0]                  pre_r, pre_nxt;
  logic [7:0]                  lse_r [3], lse_nxt [3];
  logic [7:0]                  lsr_r [3], lsr_nxt [3];
  logic [23:0]                 set_r, set_nxt;
  logic [7:0]                  dflt_r, dflt_nxt;
  logic                        rem_r, rem_nxt;
  logic                        lock_r, lock_nxt;
  logic [1:0]                  owner_r, owner_nxt;
  logic [1:0]                  pm_r, pm_nxt;
  logic [31:0]                 pip_r, pip_nxt;
  logic [31:0]                 pmask_r, pmask_nxt;
  logic [1:0]                  am_r, am_nxt;
  logic [31:0]                 aip_r, aip_nxt;
  logic [31:0]                 amask_r, amask_nxt;
  logic                        boot_r, boot_nxt;
  logic                        srq_r, srq_nxt;
  logic                        ist_r, ist_nxt;
  logic [31:0]                 rdata_r, rdata_nxt;
  logic                        take;
  logic                        store_we;
  logic [2:0]                  lsum;
  logic [7:0]                  stb;
  logic                        store_ok;
  logic                        quad_ok;
  logic                        lock_ok;
  logic [31:0]                 quad;

  assign take     = cmd_valid && rdy_r;
  assign store_ok = cmd_arg[39:6] == 34'h0 && cmd_arg[5:0] <= rcsc_pkg::STORE_MAX;
  assign quad_ok  = cmd_arg[39:38] == 2'h0 && cmd_arg[29:28] == 2'h0 &&
                    cmd_arg[19:18] == 2'h0 && cmd_arg[9:8] == 2'h0;
  assign quad     = {cmd_arg[37:30], cmd_arg[27:20], cmd_arg[17:10], cmd_arg[7:0]};
  assign lock_ok  = !iface_disabled[cmd_iface] && (!lock_r || owner_r == cmd_iface);
  assign store_we = take && cmd_op == rcsc_pkg::OP_SAV && store_ok;

  // limit status and enable registers, one per output
  genvar gi;
  generate
    for (gi = 0; gi < rcsc_pkg::NUM_OUT; gi++) begin : g_lim
      always_comb begin
        lse_nxt[gi] = lse_r[gi];
        lsr_nxt[gi] = lsr_r[gi];
        if (take && ((cmd_op == rcsc_pkg::OP_LSRQ && cmd_chan == 2'(gi)) ||
                     cmd_op == rcsc_pkg::OP_CLS)) begin
          lsr_nxt[gi] = 8'h00;
        end
        if (lim_evt[gi]) begin
          lsr_nxt[gi] = lsr_nxt[gi] | lim_bits;
        end
        if (take && cmd_op == rcsc_pkg::OP_LSE && cmd_chan == 2'(gi)) begin
          lse_nxt[gi] = cmd_arg[7:0];
        end
      end
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          lse_r[gi] <= 8'h00;
          lsr_r[gi] <= 8'h00;
        end else begin
          lse_r[gi] <= lse_nxt[gi];
          lsr_r[gi] <= lsr_nxt[gi];
        end
      end
      assign lsum[gi] = |(lsr_r[gi] & lse_r[gi]);
    end
  endgenerate

  // status byte summary
  always_comb begin
    stb = {3'h0, mav, 1'b0, lsum};
    stb[rcsc_pkg::STB_ESB] = |esr_r;
    stb[rcsc_pkg::STB_RQS] = |(stb & sre_r);
  end

  // save stores
  always_ff @(posedge sys_clk) begin
    if (store_we) begin
      store_mem[cmd_arg[5:0]] <= set_r;
    end
  end

  // command execution, responses, register port
  always_comb begin
    state_nxt   = state_r;
    idn_cnt_nxt = idn_cnt_r;
    rdy_nxt     = rdy_r;
    rv_nxt      = 1'b0;
    rd_nxt      = rd_r;
    rl_nxt      = 1'b0;
    esr_nxt     = esr_r;
    eer_nxt     = eer_r;
    qer_nxt     = qer_r;
    sre_nxt     = sre_r;
    pre_nxt     = pre_r;
    set_nxt     = set_r;
    dflt_nxt    = dflt_r;
    rem_nxt     = rem_r;
    lock_nxt    = lock_r;
    owner_nxt   = owner_r;
    pm_nxt      = pm_r;
    pip_nxt     = pip_r;
    pmask_nxt   = pmask_r;
    am_nxt      = am_r;
    aip_nxt     = aip_r;
    amask_nxt   = amask_r;
    boot_nxt    = 1'b1;
    rdata_nxt   = 32'h0;
    if (!boot_r) begin
      am_nxt    = boot_method;
      aip_nxt   = boot_ip;
      amask_nxt = boot_mask;
    end
    case (state_r)
      rcsc_pkg::ST_IDLE: begin
        rdy_nxt = 1'b1;
      end
      rcsc_pkg::ST_IDN: begin
        rv_nxt      = 1'b1;
        idn_cnt_nxt = idn_cnt_r + 2'h1;
        case (idn_cnt_r)
          2'h1:    rd_nxt = MODEL_CODE;
          2'h2:    rd_nxt = SERIAL_NUM;
          default: rd_nxt = FW_REV;
        endcase
        if (idn_cnt_r == rcsc_pkg::IDN_LAST) begin
          rl_nxt    = 1'b1;
          rdy_nxt   = 1'b1;
          state_nxt = rcsc_pkg::ST_IDLE;
        end
      end
      default: state_nxt = rcsc_pkg::ST_IDLE;
    endcase
    if (take) begin
      rem_nxt = cmd_op != rcsc_pkg::OP_LOCAL;
      rv_nxt  = 1'b1;
      rl_nxt  = 1'b1;
      rd_nxt  = 32'h0;
      case (cmd_op)
        rcsc_pkg::OP_IDNQ: begin
          rd_nxt      = MAKER_CODE;
          rl_nxt      = 1'b0;
          rdy_nxt     = 1'b0;
          idn_cnt_nxt = 2'h1;
          state_nxt   = rcsc_pkg::ST_IDN;
        end
        rcsc_pkg::OP_RST: begin
          rv_nxt  = 1'b0;
          set_nxt = {3{dflt_r}};
        end
        rcsc_pkg::OP_RCL: begin
          rv_nxt = 1'b0;
          if (store_ok) begin
            set_nxt = store_mem[cmd_arg[5:0]];
          end else begin
            eer_nxt                   = rcsc_pkg::EER_PARAM;
            esr_nxt[rcsc_pkg::ESR_EXE] = 1'b1;
          end
        end
        rcsc_pkg::OP_SAV: begin
          rv_nxt = 1'b0;
          if (!store_ok) begin
            eer_nxt                   = rcsc_pkg::EER_PARAM;
            esr_nxt[rcsc_pkg::ESR_EXE] = 1'b1;
          end
        end
        rcsc_pkg::OP_OPC: begin
          rv_nxt                     = 1'b0;
          esr_nxt[rcsc_pkg::ESR_OPC] = 1'b1;
        end
        rcsc_pkg::OP_OPCQ:  rd_nxt = 32'h1;
        rcsc_pkg::OP_TSTQ:  rd_nxt = 32'h0;
        rcsc_pkg::OP_CLS: begin
          rv_nxt  = 1'b0;
          esr_nxt = 8'h00;
          eer_nxt = 8'h00;
          qer_nxt = 8'h00;
        end
        rcsc_pkg::OP_LSRQ:  rd_nxt = {24'h0, lsr_r[cmd_chan]};
        rcsc_pkg::OP_LSEQ:  rd_nxt = {24'h0, lse_r[cmd_chan]};
        rcsc_pkg::OP_EERQ: begin
          rd_nxt  = {24'h0, eer_r};
          eer_nxt = 8'h00;
        end
        rcsc_pkg::OP_QERQ: begin
          rd_nxt  = {24'h0, qer_r};
          qer_nxt = 8'h00;
        end
        rcsc_pkg::OP_STBQ: begin
          rd_nxt                   = {24'h0, stb};
          rd_nxt[rcsc_pkg::STB_MAV] = 1'b0;
        end
        rcsc_pkg::OP_SRE: begin
          rv_nxt  = 1'b0;
          sre_nxt = cmd_arg[7:0];
        end
        rcsc_pkg::OP_SREQ:  rd_nxt = {24'h0, sre_r};
        rcsc_pkg::OP_PRE: begin
          rv_nxt  = 1'b0;
          pre_nxt = cmd_arg[7:0];
        end
        rcsc_pkg::OP_PREQ:  rd_nxt = {24'h0, pre_r};
        rcsc_pkg::OP_ISTQ:  rd_nxt = {31'h0, ist_r};
        rcsc_pkg::OP_LOCK: begin
          rv_nxt = 1'b0;
          if (lock_ok) begin
            lock_nxt  = cmd_arg[0];
            owner_nxt = cmd_iface;
          end else begin
            eer_nxt                   = rcsc_pkg::EER_LOCK;
            esr_nxt[rcsc_pkg::ESR_EXE] = 1'b1;
          end
        end
        rcsc_pkg::OP_LOCKQ: begin
          if (!lock_ok) begin
            rd_nxt = 32'hffffffff;
          end else begin
            rd_nxt = {31'h0, lock_r};
          end
        end
        rcsc_pkg::OP_NETCFG: begin
          rv_nxt = 1'b0;
          pm_nxt = cmd_arg[1:0];
        end
        rcsc_pkg::OP_IP, rcsc_pkg::OP_MASK: begin
          rv_nxt = 1'b0;
          if (!quad_ok) begin
            eer_nxt                   = rcsc_pkg::EER_PARAM;
            esr_nxt[rcsc_pkg::ESR_EXE] = 1'b1;
          end else if (cmd_op == rcsc_pkg::OP_IP) begin
            pip_nxt = quad;
          end else begin
            pmask_nxt = quad;
          end
        end
        rcsc_pkg::OP_NETCFGQ: rd_nxt = {30'h0, am_r};
        rcsc_pkg::OP_IPQ:     rd_nxt = aip_r;
        rcsc_pkg::OP_MASKQ:   rd_nxt = amask_r;
        default: rv_nxt = 1'b0;
      endcase
      rl_nxt = rl_nxt && rv_nxt;
      if ((cmd_op == rcsc_pkg::OP_RST || cmd_op == rcsc_pkg::OP_RCL) && range_blocked) begin
        eer_nxt                   = rcsc_pkg::EER_RANGE;
        esr_nxt[rcsc_pkg::ESR_EXE] = 1'b1;
      end
    end
    if (qry_err_set) begin
      qer_nxt                    = qry_err_code;
      esr_nxt[rcsc_pkg::ESR_QYE] = 1'b1;
    end
    srq_nxt = stb[rcsc_pkg::STB_RQS];
    ist_nxt = |(stb & pre_r);
    if (reg_wr && reg_addr == rcsc_pkg::REG_DEFAULT) begin
      dflt_nxt = reg_wdata[7:0];
    end
    if (reg_rd) begin
      if (reg_addr == rcsc_pkg::REG_STATUS) begin
        rdata_nxt = {4'h0, lock_r, rem_r, owner_r, eer_r, esr_r, stb};
      end else if (reg_addr == rcsc_pkg::REG_SETTINGS) begin
        rdata_nxt = {8'h0, set_r};
      end else if (reg_addr == rcsc_pkg::REG_DEFAULT) begin
        rdata_nxt = {24'h0, dflt_r};
      end else if (reg_addr == rcsc_pkg::REG_NET_IP) begin
        rdata_nxt = aip_r;
      end else if (reg_addr == rcsc_pkg::REG_NET_MASK) begin
        rdata_nxt = amask_r;
      end else begin
        rdata_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= rcsc_pkg::ST_IDLE;
      idn_cnt_r <= 2'h0;
      rdy_r     <= 1'b0;
      rv_r      <= 1'b0;
      rd_r      <= 32'h0;
      rl_r      <= 1'b0;
      esr_r     <= 8'h00;
      eer_r     <= 8'h00;
      qer_r     <= 8'h00;
      sre_r     <= 8'h00;
      pre_r     <= 8'h00;
      set_r     <= {3{rcsc_pkg::DEFAULT_RST}};
      dflt_r    <= rcsc_pkg::DEFAULT_RST;
      rem_r     <= 1'b0;
      lock_r    <= 1'b0;
      owner_r   <= 2'h0;
      pm_r      <= rcsc_pkg::METHOD_RST;
      pip_r     <= rcsc_pkg::IP_RST;
      pmask_r   <= rcsc_pkg::MASK_RST;
      am_r      <= rcsc_pkg::METHOD_RST;
      aip_r     <= rcsc_pkg::IP_RST;
      amask_r   <= rcsc_pkg::MASK_RST;
      boot_r    <= 1'b0;
      srq_r     <= 1'b0;
      ist_r     <= 1'b0;
      rdata_r   <= 32'h0;
    end else begin
      state_r   <= state_nxt;
      idn_cnt_r <= idn_cnt_nxt;
      rdy_r     <= rdy_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      rl_r      <= rl_nxt;
      esr_r     <= esr_nxt;
      eer_r     <= eer_nxt;
      qer_r     <= qer_nxt;
      sre_r     <= sre_nxt;
      pre_r     <= pre_nxt;
      set_r     <= set_nxt;
      dflt_r    <= dflt_nxt;
      rem_r     <= rem_nxt;
      lock_r    <= lock_nxt;
      owner_r   <= owner_nxt;
      pm_r      <= pm_nxt;
      pip_r     <= pip_nxt;
      pmask_r   <= pmask_nxt;
      am_r      <= am_nxt;
      aip_r     <= aip_nxt;
      amask_r   <= amask_nxt;
      boot_r    <= boot_nxt;
      srq_r     <= srq_nxt;
      ist_r     <= ist_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign cmd_ready          = rdy_r;
  assign rsp_valid          = rv_r;
  assign rsp_data           = rd_r;
  assign rsp_last           = rl_r;
  assign address_method_cmd = pm_r;
  assign static_ip_cmd      = pip_r;
  assign net_mask_cmd       = pmask_r;
  assign out_settings       = set_r;
  assign remote             = rem_r;
  assign srq                = srq_r;
  assign ist                = ist_r;
  assign reg_rdata          = rdata_r;
endmodule // rcsc_top

// File: test/rcsc_checker.sv
// assertions on the ports of the command interpreter
`timescale 1ns/1ps
module rcsc_checker #(
  parameter logic [31:0] MAKER_CODE = 32'h00000001,
  parameter logic [31:0] MODEL_CODE = 32'h00000002,
  parameter logic [31:0] SERIAL_NUM = 32'h00000003,
  parameter logic [31:0] FW_REV     = 32'h00000004
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  // command port
  input wire logic                  cmd_valid,
  input wire rcsc_pkg::rcsc_op_type cmd_op,
  input wire logic [39:0]           cmd_arg,
  input wire logic                  cmd_ready,
  input wire logic                  rsp_valid,
  input wire logic [31:0]           rsp_data,
  input wire logic                  rsp_last,
  // device state
  input wire logic                  remote,
  input wire logic [31:0]           static_ip_cmd
);
  logic        take;
  logic        quad_ok;
  logic [31:0] ip_exp;
  assign take = cmd_valid && cmd_ready;
  assign quad_ok = ~|{cmd_arg[39:38], cmd_arg[29:28], cmd_arg[19:18], cmd_arg[9:8]};
  assign ip_exp = {cmd_arg[37:30], cmd_arg[27:20], cmd_arg[17:10], cmd_arg[7:0]};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_idn_head;
    rsp_valid && !rsp_last && rsp_data == MAKER_CODE ##1
    rsp_valid && !rsp_last && rsp_data == MODEL_CODE;
  endsequence
  sequence s_idn_tail;
    rsp_valid && !rsp_last && rsp_data == SERIAL_NUM ##1
    rsp_valid && rsp_last && rsp_data == FW_REV;
  endsequence
  a_idn_words: assert property (take && cmd_op == rcsc_pkg::OP_IDNQ |=>
    s_idn_head ##1 s_idn_tail) else $error("identification words wrong");
  a_idn_busy: assert property (take && cmd_op == rcsc_pkg::OP_IDNQ |=>
    !cmd_ready [*3]) else $error("command taken during identification");
  a_opc_reply: assert property (take && cmd_op == rcsc_pkg::OP_OPCQ |=>
    rsp_valid && rsp_last && rsp_data == 32'h00000001) else $error("opc query reply wrong");
  a_selftest_zero: assert property (take && cmd_op == rcsc_pkg::OP_TSTQ |=>
    rsp_valid && rsp_last && rsp_data == 32'h00000000) else $error("self-test reply wrong");
  a_silent_cmds: assert property (take && cmd_op inside {rcsc_pkg::OP_WAI,
    rcsc_pkg::OP_TRG, rcsc_pkg::OP_OPC} |=> !rsp_valid) else $error("reply to silent command");
  a_local_mode: assert property (take && cmd_op == rcsc_pkg::OP_LOCAL |=> !remote)
    else $error("still remote after local");
  a_remote_back: assert property (take && cmd_op != rcsc_pkg::OP_LOCAL |=> remote)
    else $error("not remote after command");
  a_ip_store: assert property (take && cmd_op == rcsc_pkg::OP_IP && quad_ok |=>
    static_ip_cmd == $past(ip_exp)) else $error("static address not stored");
  a_ip_reject: assert property (take && cmd_op == rcsc_pkg::OP_IP && !quad_ok |=>
    $stable(static_ip_cmd)) else $error("bad address part accepted");
  a_last_word: assert property (rsp_last |-> rsp_valid)
    else $error("terminator without word");
endmodule // rcsc_checker

bind rcsc_top rcsc_checker #(.MAKER_CODE(MAKER_CODE), .MODEL_CODE(MODEL_CODE),
  .SERIAL_NUM(SERIAL_NUM), .FW_REV(FW_REV)) rcsc_checker_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_last(rsp_last), .remote(remote), .static_ip_cmd(static_ip_cmd));

// File: test/rcsc_host_model.sv
// model of the remote host controller issuing commands
`timescale 1ns/1ps
module rcsc_host_model (
  // clock
  input  wire logic                  sys_clk,
  // command port
  output logic                       cmd_valid,
  output rcsc_pkg::rcsc_op_type      cmd_op,
  output logic [1:0]                 cmd_chan,
  output logic [1:0]                 cmd_iface,
  output logic [39:0]                cmd_arg,
  input  wire logic                  cmd_ready,
  // responses
  input  wire logic                  rsp_valid,
  input  wire logic [31:0]           rsp_data,
  input  wire logic                  rsp_last
);
  logic [31:0] words [$];
  initial begin
    cmd_valid = 1'b0;
    cmd_op = rcsc_pkg::OP_WAI;
    cmd_chan = 2'h0;
    cmd_iface = 2'h0;
    cmd_arg = 40'h0;
  end
  // offer one command, hold it until taken, then gather the reply words
  task automatic issue(input rcsc_pkg::rcsc_op_type op, input logic [1:0] ch,
                       input logic [1:0] ifc, input logic [39:0] arg);
    int n;
    n = 0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_chan <= ch;
    cmd_iface <= ifc;
    cmd_arg <= arg;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    cmd_valid <= 1'b0;
    cmd_arg <= ~arg;
    cmd_chan <= ~ch;
    words.delete();
    n = 0;
    while (n < 8) begin
      @(posedge sys_clk);
      n++;
      if (rsp_valid === 1'b1) begin
        words.push_back(rsp_data);
        if (rsp_last === 1'b1) n = 8;
      end
    end
  endtask
endmodule // rcsc_host_model

// File: test/tb_top.sv
// self-checking bench of the command interpreter
`timescale 1ns/1ps
module tb_top;
  // identification words, arbitrary values
  localparam logic [31:0] ID_W [4] = '{32'h0000a001, 32'h0000a002, 32'h0000a003, 32'h0000a004};
  localparam logic [31:0] BOOT_IP  = 32'h0a000002;
  logic                  sys_clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  cmd_valid, cmd_ready, rsp_valid, rsp_last, remote, srq, ist;
  rcsc_pkg::rcsc_op_type cmd_op;
  logic [1:0]            cmd_chan, cmd_iface, address_method_cmd;
  logic [39:0]           cmd_arg;
  logic [31:0]           rsp_data, static_ip_cmd, net_mask_cmd, reg_wdata, reg_rdata;
  logic [23:0]           out_settings;
  logic [7:0]            reg_addr, lim_bits = 8'h00, qry_err_code = 8'h00;
  logic [2:0]            lim_evt = 3'h0;
  logic [3:0]            iface_disabled = 4'h0;
  logic                  qry_err_set = 1'b0, mav = 1'b0, range_blocked = 1'b0;
  logic                  reg_wr = 1'b0, reg_rd = 1'b0;
  int                    fail_count = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  initial reg_addr = 8'h00;
  initial reg_wdata = 32'h0;
  rcsc_top #(.MAKER_CODE(ID_W[0]), .MODEL_CODE(ID_W[1]), .SERIAL_NUM(ID_W[2]),
    .FW_REV(ID_W[3])) rcsc_top_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_chan(cmd_chan), .cmd_iface(cmd_iface), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .lim_evt(lim_evt),
    .lim_bits(lim_bits), .qry_err_set(qry_err_set), .qry_err_code(qry_err_code), .mav(mav),
    .range_blocked(range_blocked), .iface_disabled(iface_disabled), .boot_method(2'h2),
    .boot_ip(BOOT_IP), .boot_mask(32'hffff0000), .address_method_cmd(address_method_cmd),
    .static_ip_cmd(static_ip_cmd), .net_mask_cmd(net_mask_cmd), .out_settings(out_settings),
    .remote(remote), .srq(srq), .ist(ist), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rcsc_host_model rcsc_host_model_inst (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chan(cmd_chan),
    .cmd_iface(cmd_iface), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last));
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input rcsc_pkg::rcsc_op_type op, input logic [1:0] ifc,
                     input logic [39:0] arg);
    rcsc_host_model_inst.issue(op, 2'h1, ifc, arg);
  endtask
  // single-word query with its expected integer
  task automatic ask(input rcsc_pkg::rcsc_op_type op, input logic [1:0] ch,
                     input logic [1:0] ifc, input logic [31:0] exp, input string what);
    rcsc_host_model_inst.issue(op, ch, ifc, 40'h0);
    check(what, rcsc_host_model_inst.words[0], exp);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check(what, reg_rdata, exp);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reg_read(rcsc_pkg::REG_DEFAULT, 32'h0, "default reset value");
    reg_read(8'hf0, 32'h0, "unmapped read");
    rcsc_host_model_inst.issue(rcsc_pkg::OP_IDNQ, 2'h0, 2'h0, 40'h0);
    check("id word count", rcsc_host_model_inst.words.size(), 32'h4);
    for (int i = 0; i < 4; i++) check("id word", rcsc_host_model_inst.words[i], ID_W[i]);
    reg_write(rcsc_pkg::REG_DEFAULT, 32'h5a);
    cmd(rcsc_pkg::OP_RST, 2'h0, 40'h0);
    check("settings after reset", out_settings, 24'h5a5a5a);
    reg_read(rcsc_pkg::REG_NET_IP, BOOT_IP, "active address");
    cmd(rcsc_pkg::OP_SAV, 2'h0, 40'h31);
    reg_write(rcsc_pkg::REG_DEFAULT, 32'h33);
    cmd(rcsc_pkg::OP_RST, 2'h0, 40'h0);
    check("settings after reset", out_settings, 24'h333333);
    cmd(rcsc_pkg::OP_RCL, 2'h0, 40'h31);
    reg_read(rcsc_pkg::REG_SETTINGS, 32'h005a5a5a, "recalled settings");
    cmd(rcsc_pkg::OP_SAV, 2'h0, 40'h32);
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'h78, "bad store error");
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'h0, "error cleared");
    range_blocked <= 1'b1;
    cmd(rcsc_pkg::OP_RCL, 2'h0, 40'h31);
    range_blocked <= 1'b0;
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'h68, "blocked range error");
    cmd(rcsc_pkg::OP_CLS, 2'h0, 40'h0);
    cmd(rcsc_pkg::OP_OPC, 2'h0, 40'h0);
    mav <= 1'b1;
    ask(rcsc_pkg::OP_STBQ, 2'h0, 2'h0, 32'h20, "status byte");
    cmd(rcsc_pkg::OP_SRE, 2'h0, 40'h24);
    cmd(rcsc_pkg::OP_PRE, 2'h0, 40'h20);
    ask(rcsc_pkg::OP_ISTQ, 2'h0, 2'h0, 32'h1, "ist true");
    check("service request", srq, 1'b1);
    cmd(rcsc_pkg::OP_CLS, 2'h0, 40'h0);
    ask(rcsc_pkg::OP_ISTQ, 2'h0, 2'h0, 32'h0, "ist false");
    ask(rcsc_pkg::OP_STBQ, 2'h0, 2'h0, 32'h0, "status cleared");
    ask(rcsc_pkg::OP_SREQ, 2'h0, 2'h0, 32'h24, "srq enable kept");
    ask(rcsc_pkg::OP_PREQ, 2'h0, 2'h0, 32'h20, "poll enable kept");
    ask(rcsc_pkg::OP_OPCQ, 2'h0, 2'h0, 32'h1, "opc query");
    ask(rcsc_pkg::OP_TSTQ, 2'h0, 2'h0, 32'h0, "self-test");
    cmd(rcsc_pkg::OP_TRG, 2'h0, 40'h0);
    check("trigger reply", rcsc_host_model_inst.words.size(), 32'h0);
    cmd(rcsc_pkg::OP_WAI, 2'h0, 40'h0);
    check("wait reply", rcsc_host_model_inst.words.size(), 32'h0);
    @(posedge sys_clk);
    lim_bits <= 8'h81;
    lim_evt <= 3'h2;
    qry_err_set <= 1'b1;
    qry_err_code <= 8'h15;
    @(posedge sys_clk);
    lim_evt <= 3'h0;
    qry_err_set <= 1'b0;
    ask(rcsc_pkg::OP_LSRQ, 2'h1, 2'h0, 32'h81, "limit status");
    ask(rcsc_pkg::OP_LSRQ, 2'h1, 2'h0, 32'h0, "limit status cleared");
    rcsc_host_model_inst.issue(rcsc_pkg::OP_LSE, 2'h2, 2'h0, 40'h0f);
    ask(rcsc_pkg::OP_LSEQ, 2'h2, 2'h0, 32'h0f, "limit enable");
    ask(rcsc_pkg::OP_LSEQ, 2'h1, 2'h0, 32'h0, "other limit enable");
    ask(rcsc_pkg::OP_QERQ, 2'h0, 2'h0, 32'h15, "query error");
    ask(rcsc_pkg::OP_QERQ, 2'h0, 2'h0, 32'h0, "query error cleared");
    cmd(rcsc_pkg::OP_LOCK, 2'h0, 40'h1);
    ask(rcsc_pkg::OP_LOCKQ, 2'h0, 2'h0, 32'h1, "lock owned");
    ask(rcsc_pkg::OP_LOCKQ, 2'h0, 2'h1, 32'hffffffff, "lock taken");
    cmd(rcsc_pkg::OP_LOCK, 2'h1, 40'h1);
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'hc8, "lock conflict");
    cmd(rcsc_pkg::OP_LOCK, 2'h0, 40'h0);
    ask(rcsc_pkg::OP_LOCKQ, 2'h0, 2'h1, 32'h0, "lock free");
    iface_disabled <= 4'h4;
    ask(rcsc_pkg::OP_LOCKQ, 2'h0, 2'h2, 32'hffffffff, "lock disabled");
    cmd(rcsc_pkg::OP_LOCK, 2'h2, 40'h1);
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'hc8, "lock denied");
    cmd(rcsc_pkg::OP_LOCAL, 2'h0, 40'h0);
    check("local", remote, 1'b0);
    cmd(rcsc_pkg::OP_WAI, 2'h0, 40'h0);
    check("remote again", remote, 1'b1);
    cmd(rcsc_pkg::OP_IP, 2'h0, {10'h0c0, 10'h0a8, 10'h001, 10'h065});
    check("pending address", static_ip_cmd, 32'hc0a80165);
    reg_read(rcsc_pkg::REG_NET_IP, BOOT_IP, "address before power cycle");
    cmd(rcsc_pkg::OP_IP, 2'h0, {10'h100, 10'h0a8, 10'h001, 10'h065});
    check("bad part ignored", static_ip_cmd, 32'hc0a80165);
    ask(rcsc_pkg::OP_EERQ, 2'h0, 2'h0, 32'h78, "bad part error");
    cmd(rcsc_pkg::OP_MASK, 2'h0, {10'h0ff, 10'h0ff, 20'h0});
    check("mask", net_mask_cmd, 32'hffff0000);
    cmd(rcsc_pkg::OP_NETCFG, 2'h0, 40'h1);
    check("method", address_method_cmd, 2'h1);
    ask(rcsc_pkg::OP_NETCFGQ, 2'h0, 2'h0, 32'h2, "boot method");
    end_sim();
  end
endmodule // tb_top
